// *** pkg/uart_efx_cfg.svh ***
`ifndef UART_EFX_CFG_SVH
`define UART_EFX_CFG_SVH

// flow character register indices
`define CH_RESUME1 2'h0
`define CH_RESUME2 2'h1
`define CH_PAUSE1 2'h2
`define CH_PAUSE2 2'h3
`define CH_RESET 8'h00

// rx trigger levels and resume levels, by trigger select
`define TRIG_LVL_0 5'h01
`define TRIG_LVL_1 5'h04
`define TRIG_LVL_2 5'h08
`define TRIG_LVL_3 5'h0E
`define RES_LVL_0 5'h00
`define RES_LVL_1 5'h01
`define RES_LVL_2 5'h04
`define RES_LVL_3 5'h08

// pause sent this many character times after the trigger
`define FC_DELAY_CHARS 2

// infrared pulse width as a fraction of a bit time
`define IR_STD_NUM 3
`define IR_FAST_NUM 4
`define IR_FRAC_DEN 16

// word length compare masks
`define WLEN_MASK_5 8'h1F
`define WLEN_MASK_6 8'h3F
`define WLEN_MASK_7 8'h7F
`define WLEN_MASK_8 8'hFF

`endif

// *** pkg/uart_efx_pkg.sv ***
package uart_efx_pkg;

	typedef struct packed {
		logic [7:0] data;
		logic parity;
		logic frm_err;
	} rx_char_s;

	typedef struct packed {
		logic [7:0] data;
		logic par_err;
		logic frm_err;
	} fifo_word_s;

	typedef enum logic [1:0] {
		MS_IDLE,
		MS_GOT_PAUSE,
		MS_GOT_RESUME
	} match_e;

	typedef enum logic [2:0] {
		TF_IDLE,
		TF_WAIT,
		TF_PAUSE1,
		TF_PAUSE2,
		TF_SENT,
		TF_RES1,
		TF_RES2
	} txfc_e;

endpackage

// *** design/uart_efx.sv ***
// Behaviour
// [R1] compare one or two received chars
// [R2] pause match halts tx after current char
// [R3] pause match sets flag, irq if enabled
// [R4] resume match restarts tx, clears flag
// [R5] reset zeroes flow chars, software rewrites
// [R6] double mode needs two consecutive matches
// [R7] consumed flow chars never reach fifo
// [R8] auto pause two char times after trigger
// [R9] auto resume at one level below trigger
// [R10] special char pushed and flag set
// [R11] compare only word length bits
// [R12] normal multidrop when enabled, no special
// [R13] disabled: drop parity 0, tag parity 1
// [R14] software enables receiver on own address
// [R15] auto address drops data and mismatches
// [R16] matching address enables, pushed with tag
// [R17] later mismatching address disables, dropped
// [R18] ir standard mode pulse 3/16 bit
// [R19] ir fast mode pulse 1/4 bit
// [R20] sleep only when all conditions hold
// [R21] sleep stops oscillator output
// [R22] wake on rx start, thr write, modem
// [R23] resleep when cleared, modem read clears
// [R24] ir decoder: pulse gives zero bit
`include "uart_efx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_efx_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	// fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	// drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data,
	output logic [$clog2(DEPTH+1)-1:0] o_count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	wire push = i_valid & o_ready & i_clk_en;
	wire pop = o_valid & i_ready & i_clk_en;
	wire [AW-1:0] last = AW'(DEPTH - 1);

	assign o_ready = (cnt_q != CW'(DEPTH));
	assign o_valid = (cnt_q != '0);
	assign o_data = mem_q[rd_q];
	assign o_count = cnt_q;

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == last) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == last) ? '0 : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

module uart_efx #(
	parameter int OVERSAMPLE = 16,
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	// configuration
	input wire logic i_enh_access,
	input wire logic i_fc_rx_en,
	input wire logic i_fc_tx_en,
	input wire logic i_fc_double,
	input wire logic i_special_en,
	input wire logic i_multidrop,
	input wire logic i_ir_en,
	input wire logic i_ir_fast,
	input wire logic i_pause_irq_en,
	input wire logic [1:0] i_word_len,
	input wire logic [1:0] i_rx_trig,
	input wire logic [3:0] i_char_bits,
	// flow character registers
	input wire logic i_char_wr,
	input wire logic [1:0] i_char_sel,
	input wire logic [7:0] i_char_wdata,
	// receiver characters in
	input wire logic i_rx_valid,
	output logic o_rx_ready,
	input wire uart_efx_pkg::rx_char_s i_rx_char,
	input wire logic i_rx_en_sw,
	// receive fifo drain
	output logic o_rxf_valid,
	input wire logic i_rxf_ready,
	output uart_efx_pkg::fifo_word_s o_rxf_word,
	// status
	input wire logic i_isr_read,
	output logic o_flow_flag,
	output logic o_flow_irq,
	output logic o_lsr_pulse,
	output logic o_rx_enabled,
	// transmitter side
	output logic o_tx_hold,
	output logic o_fc_valid,
	input wire logic i_fc_ready,
	output logic [7:0] o_fc_char,
	input wire logic i_tx_serial,
	input wire logic i_tx_bit_start,
	// line pins
	output logic o_tx_pin,
	input wire logic i_rx_pin,
	output logic o_rx_serial,
	// sleep
	input wire logic i_int_pending,
	input wire logic i_sleep_en,
	input wire logic [3:0] i_modem_delta,
	input wire logic [3:0] i_modem_in,
	input wire logic i_rx_busy,
	input wire logic i_divisor_nonzero,
	input wire logic i_tx_fifo_empty,
	input wire logic i_thr_write,
	output logic o_sleep,
	output logic o_osc_run
);
	localparam int CW = $clog2(FIFO_DEPTH+1);
	localparam int DW = 16;
	localparam int PW = 5;
	localparam logic [PW-1:0] IR_STD =
		PW'(`IR_STD_NUM * OVERSAMPLE / `IR_FRAC_DEN);
	localparam logic [PW-1:0] IR_FAST =
		PW'(`IR_FAST_NUM * OVERSAMPLE / `IR_FRAC_DEN);
	localparam logic [PW-1:0] BIT_CLKS = PW'(OVERSAMPLE);

	// flow character registers
	logic [7:0] chars_q [4];
	for (genvar g = 0; g < 4; g++) begin : g_chars
		always_ff @(posedge i_core_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				chars_q[g] <= `CH_RESET; // R5
			end else if (i_clk_en && i_char_wr && i_char_sel == 2'(g)) begin
				chars_q[g] <= i_char_wdata; // R5
			end
		end
	end

	// character compare
	uart_efx_pkg::match_e ms_q;
	uart_efx_pkg::match_e ms_d;
	uart_efx_pkg::rx_char_s held_q;
	uart_efx_pkg::rx_char_s replay_c_q;
	logic replay_q;
	logic rx_en_q;
	logic flag_q;
	logic paused_q;
	logic lsr_q;
	wire uart_efx_pkg::rx_char_s cur = replay_q ? replay_c_q : i_rx_char;
	wire fifo_ready;
	wire take = i_clk_en & (replay_q | (i_rx_valid & o_rx_ready));
	wire [7:0] mask = (i_word_len == 2'h0) ? `WLEN_MASK_5 :
		(i_word_len == 2'h1) ? `WLEN_MASK_6 :
		(i_word_len == 2'h2) ? `WLEN_MASK_7 : `WLEN_MASK_8;
	wire [7:0] cm = cur.data & mask;
	wire eq_p1 = cm == (chars_q[`CH_PAUSE1] & mask); // R11
	wire eq_p2 = cm == (chars_q[`CH_PAUSE2] & mask); // R11
	wire eq_r1 = cm == (chars_q[`CH_RESUME1] & mask); // R11
	wire eq_r2 = cm == (chars_q[`CH_RESUME2] & mask); // R11
	wire md_on = i_multidrop & i_enh_access;
	wire md_norm = md_on & !i_special_en; // R12
	wire md_auto = md_on & i_special_en; // R15
	wire fc_on = i_fc_rx_en & !md_on;
	wire in_pair = i_fc_double & (ms_q != uart_efx_pkg::MS_IDLE);
	wire pair_ok = (ms_q == uart_efx_pkg::MS_GOT_PAUSE) ? eq_p2 : eq_r2;
	// R1 R6: single mode acts at once, double mode needs the second
	wire do_pause = fc_on &
		(i_fc_double ? (ms_q == uart_efx_pkg::MS_GOT_PAUSE && eq_p2) : eq_p1);
	wire do_resume = fc_on &
		(i_fc_double ? (ms_q == uart_efx_pkg::MS_GOT_RESUME && eq_r2) : eq_r1);
	wire first_hit = fc_on & i_fc_double & !in_pair & (eq_p1 | eq_r1);
	wire broke = fc_on & in_pair & !pair_ok;
	wire special = i_special_en & !md_on & eq_p2 & !do_pause & !first_hit;
	wire addr_ok = md_auto & cur.parity & eq_p2;
	wire addr_bad = md_auto & cur.parity & !eq_p2;
	wire rx_live = md_auto ? rx_en_q : i_rx_en_sw;

	// push decision
	logic push_cur;
	always_comb begin
		push_cur = 1'b1;
		if (md_norm) begin
			push_cur = cur.parity | i_rx_en_sw; // R13
		end else if (md_auto) begin
			push_cur = addr_ok | (!cur.parity & rx_en_q); // R15 R16 R17
		end else if (do_pause || do_resume || first_hit || broke) begin
			push_cur = 1'b0; // R7
		end
	end

	always_comb begin
		ms_d = ms_q;
		if (!fc_on || !i_fc_double || do_pause || do_resume || broke) begin
			ms_d = uart_efx_pkg::MS_IDLE;
		end else if (first_hit) begin
			ms_d = eq_p1 ? uart_efx_pkg::MS_GOT_PAUSE :
				uart_efx_pkg::MS_GOT_RESUME; // R6
		end
	end

	wire uart_efx_pkg::rx_char_s push_c = broke ? held_q : cur;
	wire push = take & (push_cur | broke);
	wire uart_efx_pkg::fifo_word_s push_w = '{data: push_c.data,
		par_err: md_on ? push_c.parity : 1'b0, frm_err: push_c.frm_err};
	wire [CW-1:0] rx_count;

	assign o_rx_ready = fifo_ready & !replay_q;

	uart_efx_fifo #(
		.WIDTH($bits(uart_efx_pkg::fifo_word_s)),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_clk_en(i_clk_en),
		.i_valid(push),
		.o_ready(fifo_ready),
		.i_data(push_w),
		.o_valid(o_rxf_valid),
		.i_ready(i_rxf_ready),
		.o_data(o_rxf_word),
		.o_count(rx_count)
	);

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ms_q <= uart_efx_pkg::MS_IDLE;
			held_q <= '0;
			replay_c_q <= '0;
			replay_q <= 1'b0;
			rx_en_q <= 1'b0;
			paused_q <= 1'b0;
			flag_q <= 1'b0;
			lsr_q <= 1'b0;
		end else if (i_clk_en) begin
			lsr_q <= 1'b0;
			replay_q <= take & broke; // mismatch pair: recheck current
			if (take) begin
				ms_q <= ms_d;
				replay_c_q <= cur;
				if (first_hit) begin
					held_q <= cur;
				end
				if (addr_ok) begin
					rx_en_q <= 1'b1; // R16
				end else if (addr_bad) begin
					rx_en_q <= 1'b0; // R17
				end
				lsr_q <= md_on & cur.parity & push_cur & !broke; // R13 R16
				if (do_pause) begin
					paused_q <= 1'b1; // R2
				end else if (do_resume) begin
					paused_q <= 1'b0; // R4
				end
			end
			if (take && (do_pause || special)) begin
				flag_q <= 1'b1; // R3 R10
			end else if ((take && do_resume) || i_isr_read) begin
				flag_q <= 1'b0; // R4
			end
		end
	end

	assign o_tx_hold = paused_q; // R2
	assign o_flow_flag = flag_q;
	assign o_flow_irq = flag_q & i_pause_irq_en; // R3
	assign o_lsr_pulse = lsr_q;
	assign o_rx_enabled = rx_live;

	// automatic pause and resume transmission
	uart_efx_pkg::txfc_e tf_q;
	logic [DW-1:0] dly_q;
	wire [CW-1:0] trig_lvl = CW'((i_rx_trig == 2'h0) ? `TRIG_LVL_0 :
		(i_rx_trig == 2'h1) ? `TRIG_LVL_1 :
		(i_rx_trig == 2'h2) ? `TRIG_LVL_2 : `TRIG_LVL_3);
	wire [CW-1:0] res_lvl = CW'((i_rx_trig == 2'h0) ? `RES_LVL_0 :
		(i_rx_trig == 2'h1) ? `RES_LVL_1 :
		(i_rx_trig == 2'h2) ? `RES_LVL_2 : `RES_LVL_3);
	wire [DW-1:0] two_chars = DW'(`FC_DELAY_CHARS * OVERSAMPLE) *
		DW'(i_char_bits);
	wire over = rx_count >= trig_lvl;
	wire under = rx_count <= res_lvl;
	wire fc_take = o_fc_valid & i_fc_ready & i_clk_en;
	wire tf_pause = (tf_q == uart_efx_pkg::TF_PAUSE1) ||
		(tf_q == uart_efx_pkg::TF_PAUSE2);

	assign o_fc_valid = tf_pause || (tf_q == uart_efx_pkg::TF_RES1) ||
		(tf_q == uart_efx_pkg::TF_RES2);
	assign o_fc_char = (tf_q == uart_efx_pkg::TF_PAUSE1) ?
		chars_q[`CH_PAUSE1] : (tf_q == uart_efx_pkg::TF_PAUSE2) ?
		chars_q[`CH_PAUSE2] : (tf_q == uart_efx_pkg::TF_RES1) ?
		chars_q[`CH_RESUME1] : chars_q[`CH_RESUME2];

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tf_q <= uart_efx_pkg::TF_IDLE;
			dly_q <= '0;
		end else if (i_clk_en) begin
			case (tf_q)
				uart_efx_pkg::TF_IDLE: begin
					dly_q <= two_chars;
					if (i_fc_tx_en && over) begin
						tf_q <= uart_efx_pkg::TF_WAIT; // R8
					end
				end
				uart_efx_pkg::TF_WAIT: begin
					dly_q <= dly_q - 1'b1;
					if (!over) begin
						tf_q <= uart_efx_pkg::TF_IDLE;
					end else if (dly_q <= DW'(1)) begin
						tf_q <= uart_efx_pkg::TF_PAUSE1; // R8
					end
				end
				uart_efx_pkg::TF_PAUSE1: begin
					if (fc_take) begin
						tf_q <= i_fc_double ? uart_efx_pkg::TF_PAUSE2 :
							uart_efx_pkg::TF_SENT;
					end
				end
				uart_efx_pkg::TF_PAUSE2: begin
					if (fc_take) begin
						tf_q <= uart_efx_pkg::TF_SENT;
					end
				end
				uart_efx_pkg::TF_SENT: begin
					if (under) begin
						tf_q <= uart_efx_pkg::TF_RES1; // R9
					end
				end
				uart_efx_pkg::TF_RES1: begin
					if (fc_take) begin
						tf_q <= i_fc_double ? uart_efx_pkg::TF_RES2 :
							uart_efx_pkg::TF_IDLE;
					end
				end
				uart_efx_pkg::TF_RES2: begin
					if (fc_take) begin
						tf_q <= uart_efx_pkg::TF_IDLE;
					end
				end
				default: begin
					tf_q <= uart_efx_pkg::TF_IDLE;
				end
			endcase
		end
	end

	// infrared encoder and decoder, pin synchronisers
	logic rx_s1_q;
	logic rx_s2_q;
	logic rx_s3_q;
	logic [3:0] md_s1_q;
	logic [3:0] md_s2_q;
	logic [3:0] md_s3_q;
	logic [PW-1:0] enc_q;
	logic [PW-1:0] dec_q;
	logic tx_pin_q;
	logic ser_q;
	logic ser_prev_q;
	logic sleep_q;
	wire ir_zero = i_ir_en & i_tx_bit_start & !i_tx_serial;
	wire [PW-1:0] ir_w = (i_ir_fast & i_enh_access) ? IR_FAST : IR_STD;
	wire [PW-1:0] enc_d = ir_zero ? ir_w : // R18 R19
		(enc_q != '0) ? enc_q - 1'b1 : '0;
	wire ir_rise = i_ir_en & rx_s2_q & !rx_s3_q;
	wire [PW-1:0] dec_d = ir_rise ? BIT_CLKS : // R24
		(dec_q != '0) ? dec_q - 1'b1 : '0;
	wire ser_d = i_ir_en ? (dec_d == '0) : rx_s2_q;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
			md_s1_q <= '0;
			md_s2_q <= '0;
			md_s3_q <= '0;
			enc_q <= '0;
			dec_q <= '0;
			tx_pin_q <= 1'b1;
			ser_q <= 1'b1;
			ser_prev_q <= 1'b1;
		end else if (i_clk_en) begin
			rx_s1_q <= i_rx_pin;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			md_s1_q <= i_modem_in;
			md_s2_q <= md_s1_q;
			md_s3_q <= md_s2_q;
			enc_q <= enc_d;
			dec_q <= dec_d;
			tx_pin_q <= i_ir_en ? (enc_d != '0) : i_tx_serial; // R18
			ser_q <= ser_d;
			ser_prev_q <= ser_q;
		end
	end

	assign o_tx_pin = tx_pin_q;
	assign o_rx_serial = ser_q;

	// sleep control
	wire wake = (ser_prev_q & !ser_q) | i_thr_write |
		(md_s2_q != md_s3_q); // R22
	wire may_sleep = !i_int_pending & i_sleep_en & (i_modem_delta == 4'h0) &
		ser_q & !i_rx_busy & i_divisor_nonzero & i_tx_fifo_empty &
		(rx_count == '0); // R20 R23

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sleep_q <= 1'b0;
		end else if (i_clk_en) begin
			sleep_q <= !wake & may_sleep; // R20 R22 R23
		end
	end

	assign o_sleep = sleep_q;
	assign o_osc_run = !sleep_q; // R21

	// checks
	a_pause_stops_tx: assert property (@(posedge i_core_clk) // R2
		disable iff (!i_resetn) (take && do_pause) |=> o_tx_hold)
		else $error("pause match did not hold transmitter");
	a_resume_clears: assert property (@(posedge i_core_clk) // R4
		disable iff (!i_resetn) (take && do_resume && !do_pause && !special)
		|=> !o_tx_hold && !o_flow_flag)
		else $error("resume match did not release transmitter");
	a_flow_not_stored: assert property (@(posedge i_core_clk) // R7
		disable iff (!i_resetn) (take && !md_on && (do_pause || do_resume))
		|-> !push)
		else $error("flow character entered receive fifo");
	a_irq_gated: assert property (@(posedge i_core_clk) // R3
		disable iff (!i_resetn) o_flow_irq |-> (o_flow_flag && i_pause_irq_en))
		else $error("flow irq without enable");
	a_addr_disable: assert property (@(posedge i_core_clk) // R17
		disable iff (!i_resetn) (take && addr_bad) |=> !o_rx_enabled || !md_auto)
		else $error("mismatching address left receiver on");
	a_addr_enable: assert property (@(posedge i_core_clk) // R16
		disable iff (!i_resetn) (take && addr_ok) |-> push ##1 o_lsr_pulse)
		else $error("matching address not stored");
	a_ir_std_pulse: assert property (@(posedge i_core_clk) // R18
		disable iff (!i_resetn || !i_clk_en)
		(ir_zero && !(i_ir_fast && i_enh_access) && OVERSAMPLE == 16)
		|=> o_tx_pin [*3] ##1 !o_tx_pin)
		else $error("ir standard pulse width wrong");
	a_sleep_conds: assert property (@(posedge i_core_clk) // R20
		disable iff (!i_resetn) $rose(o_sleep) |-> $past(i_sleep_en)
		&& $past(i_tx_fifo_empty) && !$past(i_int_pending))
		else $error("sleep entered with conditions unmet");
	a_wake_on_write: assert property (@(posedge i_core_clk) // R22
		disable iff (!i_resetn) (i_clk_en && i_thr_write) |=> !o_sleep)
		else $error("thr write did not wake");
	a_osc_stops: assert property (@(posedge i_core_clk) // R21
		disable iff (!i_resetn) o_sleep |-> !o_osc_run)
		else $error("oscillator runs during sleep");
endmodule

`default_nettype wire

// *** testbench/uart_efx_remote.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_efx_remote (
	// clock
	input wire logic i_core_clk,
	// characters towards the block
	output logic o_rx_valid,
	input wire logic i_rx_ready,
	output uart_efx_pkg::rx_char_s o_rx_char,
	// flow characters from the block
	input wire logic i_fc_valid,
	output logic o_fc_ready,
	input wire logic [7:0] i_fc_char
);
	logic slow;
	logic [7:0] got[$];
	initial begin
		o_rx_valid = 1'b0;
		o_rx_char = '0;
		o_fc_ready = 1'b0;
		slow = 1'b1;
	end
	// stalls every other cycle when slow
	always @(posedge i_core_clk) begin
		o_fc_ready <= slow ? ~o_fc_ready : 1'b1;
		if (i_fc_valid === 1'b1 && o_fc_ready === 1'b1)
			got.push_back(i_fc_char);
	end
	// parity bit marks an address byte
	task automatic send(input logic [7:0] d, input logic p);
		o_rx_valid <= 1'b1;
		o_rx_char <= '{data: d, parity: p, frm_err: 1'b0};
		@(negedge i_core_clk);
		while (i_rx_ready !== 1'b1)
			@(negedge i_core_clk);
		@(posedge i_core_clk);
		o_rx_valid <= 1'b0;
		o_rx_char <= ~o_rx_char;
		@(posedge i_core_clk);
	endtask
endmodule
`default_nettype wire

// *** testbench/test_uart_efx.sv ***
`include "uart_efx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_uart_efx;
	logic clk = 1'b0, resetn = 1'b0, enh = 1'b0, fc_rx = 1'b0;
	logic fc_tx = 1'b0, dbl = 1'b0, spec = 1'b0, mdrop = 1'b0;
	logic ir = 1'b0, ir_fast = 1'b0, irq_en = 1'b1, wr = 1'b0;
	logic [1:0] wlen = 2'h3, trig = 2'h1, sel = 2'h0;
	logic [3:0] cbits = 4'h2, mdelta = 4'h0, modem = 4'h0;
	logic [7:0] wdata = 8'h00, fc_char;
	logic rxf_ready = 1'b0, isr_rd = 1'b0, en_sw = 1'b1, tx_ser = 1'b1;
	logic bit_st = 1'b0, rx_pin = 1'b1, int_pend = 1'b0, sl_en = 1'b0;
	logic div_nz = 1'b1, thr_wr = 1'b0;
	logic rx_valid, rx_ready, rxf_valid, flag, irq, line_status_reg, rx_on, hold;
	logic fc_valid, fc_ready, tx_pin, rx_ser, sleep, osc;
	uart_efx_pkg::rx_char_s rx_char;
	uart_efx_pkg::fifo_word_s rxf_word;
	int fails = 0, comparisons = 0, lsr_n = 0, n;
	always #50 clk = ~clk;
	always @(posedge clk) if (line_status_reg === 1'b1) lsr_n++;
	uart_efx uart_efx_i (.i_core_clk(clk), .i_resetn(resetn),
		.i_clk_en(1'b1), .i_enh_access(enh), .i_fc_rx_en(fc_rx),
		.i_fc_tx_en(fc_tx), .i_fc_double(dbl), .i_special_en(spec),
		.i_multidrop(mdrop), .i_ir_en(ir), .i_ir_fast(ir_fast),
		.i_pause_irq_en(irq_en), .i_word_len(wlen), .i_rx_trig(trig),
		.i_char_bits(cbits), .i_char_wr(wr), .i_char_sel(sel),
		.i_char_wdata(wdata), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready),
		.i_rx_char(rx_char), .i_rx_en_sw(en_sw), .o_rxf_valid(rxf_valid),
		.i_rxf_ready(rxf_ready), .o_rxf_word(rxf_word),
		.i_isr_read(isr_rd), .o_flow_flag(flag), .o_flow_irq(irq),
		.o_lsr_pulse(line_status_reg), .o_rx_enabled(rx_on), .o_tx_hold(hold),
		.o_fc_valid(fc_valid), .i_fc_ready(fc_ready), .o_fc_char(fc_char),
		.i_tx_serial(tx_ser), .i_tx_bit_start(bit_st), .o_tx_pin(tx_pin),
		.i_rx_pin(rx_pin), .o_rx_serial(rx_ser), .i_int_pending(int_pend),
		.i_sleep_en(sl_en), .i_modem_delta(mdelta), .i_modem_in(modem),
		.i_rx_busy(1'b0), .i_divisor_nonzero(div_nz),
		.i_tx_fifo_empty(1'b1), .i_thr_write(thr_wr), .o_sleep(sleep),
		.o_osc_run(osc));
	uart_efx_remote uart_efx_remote_i (.i_core_clk(clk),
		.o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .o_rx_char(rx_char),
		.i_fc_valid(fc_valid), .o_fc_ready(fc_ready), .i_fc_char(fc_char));
	task automatic chk_bit(input string s, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic chk_char(input string s, input logic [7:0] e,
		input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic chk_word(input string s,
		input uart_efx_pkg::fifo_word_s e, input uart_efx_pkg::fifo_word_s g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic tx(input logic [7:0] d, input logic p);
		uart_efx_remote_i.send(d, p);
	endtask
	task automatic wr_char(input logic [1:0] s, input logic [7:0] d);
		wr <= 1'b1;
		sel <= s;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic pop(input logic [7:0] d, input logic pe);
		rxf_ready <= 1'b1;
		@(negedge clk);
		for (int k = 0; k < 20 && rxf_valid !== 1'b1; k++) @(negedge clk);
		chk_word("rxf_word", '{data: d, par_err: pe, frm_err: 1'b0}, rxf_word);
		@(posedge clk);
		rxf_ready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic none();
		repeat (3) @(negedge clk);
		chk_bit("rxf_valid", 1'b0, rxf_valid);
		@(posedge clk);
	endtask
	task automatic t_reset();
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk_bit("tx_pin", 1'b1, tx_pin);
		chk_bit("rx_serial", 1'b1, rx_ser);
		chk_bit("sleep", 1'b0, sleep);
		chk_bit("osc_run", 1'b1, osc);
		chk_bit("fc_valid", 1'b0, fc_valid);
		@(posedge clk);
		resetn <= 1'b1;
		fc_rx <= 1'b1;
		@(posedge clk);
		tx(8'h00, 1'b0);
		none();
		chk_bit("tx_hold", 1'b1, hold);
		wr_char(`CH_PAUSE1, 8'h13);
		wr_char(`CH_RESUME1, 8'h11);
		tx(8'h00, 1'b0);
		pop(8'h00, 1'b0);
		tx(8'h11, 1'b0);
		@(negedge clk);
		chk_bit("tx_hold", 1'b0, hold);
		chk_bit("flow_flag", 1'b0, flag);
		@(posedge clk);
		$display("reset test done");
	endtask
	task automatic t_flow();
		tx(8'h13, 1'b0);
		@(negedge clk);
		chk_bit("tx_hold", 1'b1, hold);
		chk_bit("flow_flag", 1'b1, flag);
		chk_bit("flow_irq", 1'b1, irq);
		@(posedge clk);
		irq_en <= 1'b0;
		@(negedge clk);
		chk_bit("flow_irq", 1'b0, irq);
		@(posedge clk);
		irq_en <= 1'b1;
		none();
		tx(8'h11, 1'b0);
		@(negedge clk);
		chk_bit("tx_hold", 1'b0, hold);
		chk_bit("flow_flag", 1'b0, flag);
		@(posedge clk);
		dbl <= 1'b1;
		wr_char(`CH_PAUSE2, 8'h93);
		wr_char(`CH_RESUME2, 8'h91);
		tx(8'h13, 1'b0);
		tx(8'h41, 1'b0);
		pop(8'h13, 1'b0);
		pop(8'h41, 1'b0);
		tx(8'h13, 1'b0);
		tx(8'h93, 1'b0);
		@(negedge clk);
		chk_bit("tx_hold", 1'b1, hold);
		none();
		tx(8'h11, 1'b0);
		tx(8'h91, 1'b0);
		@(negedge clk);
		chk_bit("tx_hold", 1'b0, hold);
		@(posedge clk);
		dbl <= 1'b0;
		fc_rx <= 1'b0;
		$display("flow test done");
	endtask
	task automatic t_special();
		spec <= 1'b1;
		wlen <= 2'h0;
		wr_char(`CH_PAUSE2, 8'h3A);
		tx(8'hFA, 1'b0);
		@(negedge clk);
		chk_bit("flow_flag", 1'b1, flag);
		@(posedge clk);
		pop(8'hFA, 1'b0);
		isr_rd <= 1'b1;
		@(posedge clk);
		isr_rd <= 1'b0;
		tx(8'hFB, 1'b0);
		@(negedge clk);
		chk_bit("flow_flag", 1'b0, flag);
		@(posedge clk);
		pop(8'hFB, 1'b0);
		$display("special test done");
	endtask
	task automatic t_multidrop();
		enh <= 1'b1;
		mdrop <= 1'b1;
		wlen <= 2'h3;
		wr_char(`CH_PAUSE2, 8'h5A);
		tx(8'h77, 1'b0);
		tx(8'h33, 1'b1);
		none();
		n = lsr_n;
		tx(8'h5A, 1'b1);
		pop(8'h5A, 1'b1);
		chk_bit("rx_enabled", 1'b1, rx_on);
		chk_bit("lsr_pulse", 1'b1, lsr_n == n + 1);
		tx(8'h66, 1'b0);
		pop(8'h66, 1'b0);
		tx(8'h33, 1'b1);
		none();
		chk_bit("rx_enabled", 1'b0, rx_on);
		spec <= 1'b0;
		en_sw <= 1'b0;
		n = lsr_n;
		tx(8'h44, 1'b0);
		none();
		tx(8'h21, 1'b1);
		pop(8'h21, 1'b1);
		chk_bit("lsr_pulse", 1'b1, lsr_n == n + 1);
		en_sw <= 1'b1;
		tx(8'h55, 1'b0);
		pop(8'h55, 1'b0);
		mdrop <= 1'b0;
		enh <= 1'b0;
		$display("multidrop test done");
	endtask
	task automatic t_auto_fc();
		fc_tx <= 1'b1;
		for (int i = 1; i <= 4; i++) tx(8'(i), 1'b0);
		repeat (60) @(negedge clk);
		chk_bit("fc_valid", 1'b0, fc_valid);
		for (int k = 0; k < 60 && uart_efx_remote_i.got.size() == 0; k++)
			@(negedge clk);
		chk_char("pause_sent", 8'h13, uart_efx_remote_i.got[0]);
		@(posedge clk);
		pop(8'h01, 1'b0);
		pop(8'h02, 1'b0);
		repeat (10) @(negedge clk);
		chk_bit("resume_early", 1'b1, uart_efx_remote_i.got.size() == 1);
		@(posedge clk);
		pop(8'h03, 1'b0);
		for (int k = 0; k < 20 && uart_efx_remote_i.got.size() < 2; k++)
			@(negedge clk);
		chk_char("resume_sent", 8'h11, uart_efx_remote_i.got[1]);
		@(posedge clk);
		pop(8'h04, 1'b0);
		fc_tx <= 1'b0;
		$display("auto flow test done");
	endtask
	task automatic ir_pulse(input logic [7:0] e);
		tx_ser <= 1'b0;
		bit_st <= 1'b1;
		@(posedge clk);
		bit_st <= 1'b0;
		n = 0;
		repeat (10) begin
			@(negedge clk);
			n += (tx_pin === 1'b1);
		end
		@(posedge clk);
		tx_ser <= 1'b1;
		@(posedge clk);
		chk_char("ir_pulse", e, 8'(n));
	endtask
	task automatic t_ir();
		ir <= 1'b1;
		rx_pin <= 1'b0;
		ir_pulse(8'h03);
		enh <= 1'b1;
		ir_fast <= 1'b1;
		ir_pulse(8'h04);
		repeat (4) @(posedge clk);
		rx_pin <= 1'b1;
		repeat (2) @(posedge clk);
		rx_pin <= 1'b0;
		n = 0;
		repeat (30) begin
			@(negedge clk);
			n += (rx_ser === 1'b0);
		end
		chk_char("ir_decode", 8'h10, 8'(n));
		@(posedge clk);
		ir <= 1'b0;
		ir_fast <= 1'b0;
		enh <= 1'b0;
		rx_pin <= 1'b1;
		$display("infrared test done");
	endtask
	task automatic wake(input string s);
		for (int k = 0; k < 8 && sleep !== 1'b0; k++) @(negedge clk);
		chk_bit(s, 1'b0, sleep);
		@(posedge clk);
	endtask
	task automatic asleep(input logic e);
		repeat (6) @(negedge clk);
		chk_bit("sleep", e, sleep);
		chk_bit("osc_run", ~e, osc);
		@(posedge clk);
	endtask
	task automatic t_sleep();
		repeat (8) @(posedge clk);
		div_nz <= 1'b0;
		sl_en <= 1'b1;
		asleep(1'b0);
		div_nz <= 1'b1;
		asleep(1'b1);
		thr_wr <= 1'b1;
		@(posedge clk);
		thr_wr <= 1'b0;
		wake("wake_thr");
		asleep(1'b1);
		modem <= 4'h1;
		mdelta <= 4'h1;
		wake("wake_modem");
		asleep(1'b0);
		mdelta <= 4'h0;
		asleep(1'b1);
		rx_pin <= 1'b0;
		wake("wake_rx");
		rx_pin <= 1'b1;
		int_pend <= 1'b1;
		asleep(1'b0);
		int_pend <= 1'b0;
		asleep(1'b1);
		$display("sleep test done");
	endtask
	task automatic final_report();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		t_reset();
		t_flow();
		t_special();
		t_multidrop();
		t_auto_fc();
		t_ir();
		t_sleep();
		final_report();
	end
	initial begin
		#3000000;
		fails++;
		final_report();
	end
endmodule
`default_nettype wire
